// >>> bstap_top.v
// Boundary-scan test access port of a pipelined memory.
// Assumes test pins asynchronous to clk, test clock well under clk/8.
// Assumes memory pins steady around Capture-DR.
`timescale 1ns/1ps
`default_nettype none
`include "bstap_defs.vh"
module bstap_top (
  // Clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Width strap, high for wide configuration
  input wire wide_cfg,
  // Test pins
  input wire test_clk,
  input wire test_mode_sel,
  input wire test_data_in,
  output reg test_data_out,
  output reg test_data_out_oe_n,
  // Memory pin ring to sample
  input wire [`BSTAP_BSR_W-1:0] pin_ring,
  // Memory output float request
  output reg mem_out_float,
  // Controller state for observation
  output reg [15:0] tap_state
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDS = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SDR = 16'h0010;
  localparam [15:0] S_E1D = 16'h0020;
  localparam [15:0] S_PDR = 16'h0040;
  localparam [15:0] S_E2D = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100;
  localparam [15:0] S_SIS = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SIR = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000;
  localparam [15:0] S_PIR = 16'h2000;
  localparam [15:0] S_E2I = 16'h4000;
  localparam [15:0] S_UIR = 16'h8000;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire tck_rise;
  wire tck_fall;
  wire tms_lvl;
  wire tdi_lvl;
  wire [`BSTAP_BSR_W-1:0] ring_lvl;
  bstap_sync u_tck (
    .clk(clk), .rst_n(rst_n), .ce(ce), .pin(test_clk),
    .lvl(), .rise(tck_rise), .fall(tck_fall)
  );
  bstap_sync u_tms (
    .clk(clk), .rst_n(rst_n), .ce(ce), .pin(test_mode_sel),
    .lvl(tms_lvl), .rise(), .fall()
  );
  bstap_sync u_tdi (
    .clk(clk), .rst_n(rst_n), .ce(ce), .pin(test_data_in),
    .lvl(tdi_lvl), .rise(), .fall()
  );
  genvar gi;
  generate
    for (gi = 0; gi < `BSTAP_BSR_W; gi = gi + 1) begin : g_ring
      bstap_sync u_ring (
        .clk(clk), .rst_n(rst_n), .ce(ce), .pin(pin_ring[gi]),
        .lvl(ring_lvl[gi]), .rise(), .fall()
      );
    end
  endgenerate

  // ----------------------------------------
  // Controller state machine
  // ----------------------------------------
  reg [15:0] state_r;
  reg [15:0] state_nxt;
  reg [2:0] tms_hi_r;
  always @* begin
    state_nxt = S_TLR;
    case (state_r)
      S_TLR: state_nxt = tms_lvl ? S_TLR : S_RTI;
      S_RTI: state_nxt = tms_lvl ? S_SDS : S_RTI;
      S_SDS: state_nxt = tms_lvl ? S_SIS : S_CDR;
      S_CDR: state_nxt = tms_lvl ? S_E1D : S_SDR;
      S_SDR: state_nxt = tms_lvl ? S_E1D : S_SDR;
      S_E1D: state_nxt = tms_lvl ? S_UDR : S_PDR;
      S_PDR: state_nxt = tms_lvl ? S_E2D : S_PDR;
      S_E2D: state_nxt = tms_lvl ? S_UDR : S_SDR;
      S_UDR: state_nxt = tms_lvl ? S_SDS : S_RTI;
      S_SIS: state_nxt = tms_lvl ? S_TLR : S_CIR;
      S_CIR: state_nxt = tms_lvl ? S_E1I : S_SIR;
      S_SIR: state_nxt = tms_lvl ? S_E1I : S_SIR;
      S_E1I: state_nxt = tms_lvl ? S_UIR : S_PIR;
      S_PIR: state_nxt = tms_lvl ? S_E2I : S_PIR;
      S_E2I: state_nxt = tms_lvl ? S_UIR : S_SIR;
      S_UIR: state_nxt = tms_lvl ? S_SDS : S_RTI;
      default: state_nxt = S_TLR;
    endcase
  end

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  reg [`BSTAP_IR_W-1:0] ir_r;
  reg [`BSTAP_IR_W-1:0] ir_sh_r;
  reg [`BSTAP_ID_W-1:0] id_sh_r;
  reg [`BSTAP_BSR_W-1:0] bsr_r;
  reg byp_r;
  reg [1:0] sel_r;
  localparam [1:0] SEL_BSR = 2'h0;
  localparam [1:0] SEL_ID = 2'h1;
  localparam [1:0] SEL_BYP = 2'h2;

  function [2:0] bstap_dec;
    input [`BSTAP_IR_W-1:0] code;
    begin
      case (code)
        `BSTAP_IR_FLOATCAP: bstap_dec = {1'b1, SEL_BSR};
        `BSTAP_IR_IDREAD: bstap_dec = {1'b0, SEL_ID};
        `BSTAP_IR_SAMPLEZ: bstap_dec = {1'b1, SEL_BSR};
        `BSTAP_IR_SAMPLE: bstap_dec = {1'b0, SEL_BSR};
        `BSTAP_IR_BYPASS: bstap_dec = {1'b0, SEL_BYP};
        // reserved codes fall back to bypass
        default: bstap_dec = {1'b0, SEL_BYP};
      endcase
    end
  endfunction

  wire [2:0] dec = bstap_dec(ir_r);
  wire [1:0] dec_sel = dec[1:0];
  wire dec_float = dec[2];
  wire in_shift = (state_r == S_SIR) || (state_r == S_SDR);

  // ----------------------------------------
  // Boundary shift path
  // ----------------------------------------
  reg [`BSTAP_BSR_W-1:0] bsr_nxt;
  // data-in at top bit of active length
  always @* begin
    if (wide_cfg) begin
      bsr_nxt = {tdi_lvl, bsr_r[`BSTAP_BSR_W-1:1]};
    end else begin
      bsr_nxt = {{(`BSTAP_BSR_W - `BSTAP_BSR_W18){1'b0}}, tdi_lvl, bsr_r[`BSTAP_BSR_W18-1:1]};
    end
  end

  // ----------------------------------------
  // Mode-select reset counter
  // ----------------------------------------
  wire tms_force;
  wire [15:0] state_go;
  wire enter_tlr;
  assign tms_force = tms_lvl && (tms_hi_r == (`BSTAP_RST_TMS_EDGES - 1));
  assign state_go = tms_force ? S_TLR : state_nxt;
  assign enter_tlr = (state_go == S_TLR);
  always @(posedge clk) begin
    if (!rst_n) begin
      tms_hi_r <= 3'h0;
    end else if (ce && tck_rise) begin
      if (!tms_lvl) begin
        tms_hi_r <= 3'h0;
      end else if (!tms_force) begin
        tms_hi_r <= tms_hi_r + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Controller and instruction register
  // ----------------------------------------

  always @(posedge clk) begin
    if (!rst_n) begin
      state_r <= S_TLR;
      ir_r <= `BSTAP_IR_IDREAD;
      ir_sh_r <= 3'h0;
      sel_r <= SEL_ID;
    end else if (ce && tck_rise) begin
      state_r <= state_go;
      case (state_r)
        S_CIR: begin
          ir_sh_r <= {ir_r[2], `BSTAP_IR_CAPT};
        end
        S_SIR: begin
          ir_sh_r <= {tdi_lvl, ir_sh_r[2:1]};
        end
        S_UIR: begin
          ir_r <= ir_sh_r;
        end
        S_CDR: begin
          sel_r <= dec_sel;
        end
        default: begin
        end
      endcase
      if (enter_tlr) begin
        ir_r <= `BSTAP_IR_IDREAD;
        sel_r <= SEL_ID;
      end
    end
  end

  // ----------------------------------------
  // Data registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      id_sh_r <= 32'h0000_0000;
      bsr_r <= {`BSTAP_BSR_W{1'b0}};
      byp_r <= 1'b0;
    end else if (ce && tck_rise) begin
      case (state_r)
        S_CDR: begin
          if (dec_sel == SEL_ID) begin
            id_sh_r <= `BSTAP_IDCODE;
          end
          if (dec_sel == SEL_BSR) begin
            bsr_r <= ring_lvl;
          end
          if (dec_sel == SEL_BYP) begin
            byp_r <= 1'b0;
          end
        end
        S_SDR: begin
          if (sel_r == SEL_BSR) begin
            bsr_r <= bsr_nxt;
          end
          if (sel_r == SEL_ID) begin
            id_sh_r <= {tdi_lvl, id_sh_r[31:1]};
          end
          if (sel_r == SEL_BYP) begin
            byp_r <= tdi_lvl;
          end
        end
        // nothing is driven into the memory
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Falling test clock outputs
  // ----------------------------------------
  reg out_bit;
  // data-out from selected register low bit
  always @* begin
    out_bit = byp_r;
    if (state_r == S_SIR) begin
      out_bit = ir_sh_r[0];
    end else if (sel_r == SEL_ID) begin
      out_bit = id_sh_r[0];
    end else if (sel_r == SEL_BSR) begin
      out_bit = bsr_r[0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      test_data_out <= 1'b0;
      test_data_out_oe_n <= 1'b1;
    end else if (ce && tck_fall) begin
      test_data_out <= out_bit;
      test_data_out_oe_n <= ~in_shift;
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      mem_out_float <= 1'b0;
      tap_state <= S_TLR;
    end else if (ce) begin
      tap_state <= state_r;
      mem_out_float <= dec_float;
    end
  end
endmodule
`default_nettype wire

// >>> bstap_defs.vh
// Constants for the boundary-scan test port.
// Assumes inclusion by bare name from the design files.
`ifndef BSTAP_DEFS_VH
`define BSTAP_DEFS_VH
// Instruction codes
`define BSTAP_IR_W 3
`define BSTAP_IR_FLOATCAP 3'h0
`define BSTAP_IR_IDREAD 3'h1
`define BSTAP_IR_SAMPLEZ 3'h2
`define BSTAP_IR_RSV3 3'h3
`define BSTAP_IR_SAMPLE 3'h4
`define BSTAP_IR_RSV5 3'h5
`define BSTAP_IR_RSV6 3'h6
`define BSTAP_IR_BYPASS 3'h7
// Capture-IR pattern in the two low bits
`define BSTAP_IR_CAPT 2'h1
// Register lengths
`define BSTAP_ID_W 32
`define BSTAP_BSR_W 70
`define BSTAP_BSR_W18 51
// Identification value, arbitrary neutral value, bit 0 marks presence
`define BSTAP_IDCODE 32'h0a5a_5001
// Held-high count for reset
`define BSTAP_RST_TMS_EDGES 5
`endif

// >>> bstap_sync.v
// Two-flop synchroniser with rise and fall pulses for the test pins.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module bstap_sync (
  // Clock and control
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Pin and result
  input wire pin,
  output reg lvl,
  output reg rise,
  output reg fall
);
  reg meta_r;
  reg sync_r;
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      lvl <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else if (ce) begin
      meta_r <= pin;
      sync_r <= meta_r;
      lvl <= sync_r;
      rise <= sync_r & ~lvl;
      fall <= ~sync_r & lvl;
    end
  end
endmodule
`default_nettype wire

// >>> bstap_checker.sv
// Concurrent checks on the boundary-scan test port pins.
// Assumes ce held high and a test clock slower than clk/8.
`timescale 1ns/1ps
`default_nettype none
module bstap_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Test pins
  input wire logic test_clk,
  input wire logic test_data_out,
  input wire logic test_data_out_oe_n,
  // Status
  input wire logic mem_out_float,
  input wire logic [15:0] tap_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  state_onehot_a: assert property ($onehot(tap_state))
    else $error("controller state not one-hot");
  reset_state_a: assert property ($rose(rst_n) |->
    tap_state == 16'h0001 && test_data_out_oe_n && !mem_out_float)
    else $error("wrong state after reset");
  oe_on_shift_a: assert property ($fell(test_data_out_oe_n) |->
    tap_state[4] || tap_state[11])
    else $error("data-out enabled outside shift");
  oe_off_a: assert property ($rose(test_data_out_oe_n) |->
    !(tap_state[4] || tap_state[11]))
    else $error("data-out released in shift");
  out_on_fall_a: assert property ($changed(test_data_out) |-> !test_clk)
    else $error("data-out moved with test clock high");
  state_on_rise_a: assert property ($changed(tap_state) |-> test_clk)
    else $error("state moved with test clock low");
  reset_float_a: assert property (tap_state[0] [*4] |-> !mem_out_float)
    else $error("outputs floated in test reset");
  float_update_a: assert property ($changed(mem_out_float) |->
    tap_state[15] || tap_state[0] || $past(tap_state[15]) || $past(tap_state[0]))
    else $error("float changed outside update");
  reset_exit_a: assert property ($changed(tap_state) && $past(tap_state[0]) |->
    tap_state[1])
    else $error("bad exit from test reset");
endmodule
`default_nettype wire

// >>> bstap_master.sv
// Serial test master model for the boundary-scan port.
// Assumes it starts each scan from Run-Test-Idle.
`timescale 1ns/1ps
`default_nettype none
module bstap_master (
  // Test pins driven
  output var logic test_clk,
  output var logic test_mode_sel,
  output var logic test_data_in,
  // Test pins read
  input wire logic test_data_out,
  input wire logic test_data_out_oe_n
);
  logic tdo_w;
  // Released data-out shows the inverse of its last value
  assign tdo_w = test_data_out_oe_n ? ~test_data_out : test_data_out;
  initial begin
    test_clk = 0;
    test_mode_sel = 1;
    test_data_in = 1;
  end
  task automatic step(input logic m, input logic d, output logic o);
    test_mode_sel = m;
    test_data_in = d;
    #62.5;
    test_clk = 1;
    o = tdo_w;
    #62.5;
    test_clk = 0;
  endtask
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic b;
    dout = '0;
    step(1, 1, b);
    if (ir) step(1, 1, b);
    step(0, 1, b);
    step(0, 1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1, 1, b);
    step(0, 1, b);
  endtask
  // one low select edge, test reset to idle
  task automatic idle;
    logic b;
    step(0, 1, b);
  endtask
  task automatic reset5;
    logic b;
    repeat (5) step(1, 1, b);
    step(0, 1, b);
  endtask
endmodule
`default_nettype wire

// >>> bstap_top_test.sv
// Self-checking bench for the boundary-scan test port.
// Assumes the master model drives the test pins.
`timescale 1ns/1ps
`default_nettype none
`include "bstap_defs.vh"
module bstap_top_test;
  typedef struct {
    logic [2:0] code;
    logic wide;
    int n;
    logic [127:0] exp;
    logic flt;
  } bstap_row_t;
  localparam logic [127:0] TDI_PAT = 128'hc3a5_96e1;
  localparam logic [`BSTAP_BSR_W-1:0] PINS = 70'h2a_5c3e_910b_74d1_68f0;
  logic clk, rst_n, wide_cfg;
  logic [`BSTAP_BSR_W-1:0] pin_ring;
  wire test_clk, test_mode_sel, test_data_in, test_data_out, test_data_out_oe_n;
  wire mem_out_float;
  wire [15:0] tap_state;
  logic [127:0] dout;
  bstap_row_t rows [5];
  int n_mismatch, checks;
  bstap_top i_bstap_top (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .wide_cfg(wide_cfg), .test_clk(test_clk),
    .test_mode_sel(test_mode_sel), .test_data_in(test_data_in), .test_data_out(test_data_out),
    .test_data_out_oe_n(test_data_out_oe_n), .pin_ring(pin_ring),
    .mem_out_float(mem_out_float), .tap_state(tap_state));
  bstap_master i_bstap_master (
    .test_clk(test_clk), .test_mode_sel(test_mode_sel), .test_data_in(test_data_in),
    .test_data_out(test_data_out), .test_data_out_oe_n(test_data_out_oe_n));
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    $display("CHECK FAILED timeout expected finish seen hang");
    summarize;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 0;
    wide_cfg = 1;
    pin_ring = PINS;
    rows[0] = '{3'h0, 1'b1, 78, 128'({TDI_PAT[7:0], PINS}), 1'b1};
    rows[1] = '{3'h1, 1'b1, 64, 128'({TDI_PAT[31:0], `BSTAP_IDCODE}), 1'b0};
    rows[2] = '{3'h2, 1'b0, 59, 128'({TDI_PAT[7:0], PINS[50:0]}), 1'b1};
    rows[3] = '{3'h4, 1'b1, 78, 128'({TDI_PAT[7:0], PINS}), 1'b0};
    rows[4] = '{3'h7, 1'b1, 8, 128'({TDI_PAT[6:0], 1'b0}), 1'b0};
    repeat (3) @(posedge clk);
    #1;
    check("reset state", 128'(tap_state), 128'h0001);
    check("reset oe", 128'(test_data_out_oe_n), 128'h1);
    rst_n = 1;
    repeat (5) @(posedge clk);
    #1;
    i_bstap_master.idle;
    check("idle state", 128'(tap_state), 128'h0002);
    i_bstap_master.scan(0, 32, TDI_PAT, dout);
    check("id at power-up", dout, 128'(`BSTAP_IDCODE));
    $display("test power-up done");
    for (int r = 0; r < 5; r++) begin
      @(posedge clk) #1 wide_cfg = rows[r].wide;
      i_bstap_master.scan(1, 3, 128'(rows[r].code), dout);
      check("ir capture", 128'(dout[1:0]), 128'h1);
      check("oe idle", 128'(test_data_out_oe_n), 128'h1);
      check("float", 128'(mem_out_float), 128'(rows[r].flt));
      i_bstap_master.scan(0, rows[r].n, TDI_PAT, dout);
      check("scan out", dout, rows[r].exp);
      $display("test row %0d done", r);
    end
    i_bstap_master.scan(1, 3, 128'h0, dout);
    check("float on", 128'(mem_out_float), 128'h1);
    i_bstap_master.reset5;
    check("float off", 128'(mem_out_float), 128'h0);
    i_bstap_master.scan(0, 32, TDI_PAT, dout);
    check("id after reset", dout, 128'(`BSTAP_IDCODE));
    $display("test mode-select reset done");
    summarize;
  end
endmodule
bind bstap_top bstap_checker i_bstap_checker (
  .clk(clk), .rst_n(rst_n), .test_clk(test_clk), .test_data_out(test_data_out),
  .test_data_out_oe_n(test_data_out_oe_n), .mem_out_float(mem_out_float),
  .tap_state(tap_state));
`default_nettype wire
